/* rtl/clock_source_control.sv */
// clock source selection, divide and glitch-free start gate
`timescale 1ns/100ps
// Function
// - internal core clock is the crystal oscillator divided by ten
// - gate bit clear: no clock to core or pin; set passes source
// - internal clock drives the pin only when pin output enable is set
// - oscillator power-down stops crystal, pin becomes input, output ignored
// - external pin clock reaches the core only once the gate is set
// - multi-chip: one master drives pin, others power down and listen
// - crystals 3.7 to 4.5 MHz accepted, rates scale with frequency
module clock_source_control
  import clock_source_pkg::*;
#(
  parameter int DIV_RATIO = CORE_DIV
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input oscillator_control_t ctrl,
  input wire logic xtalClk,
  input wire logic clkPinIn,
  output logic oscEnable,
  output logic clkPinOut,
  output logic clkPinOe_n,
  output logic coreClk,
  output logic coreClkEn
);

  localparam int HALF = DIV_RATIO / 2;
  localparam int CW = $clog2(HALF + 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(HALF - 1);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (DIV_RATIO < 2 || (DIV_RATIO % 2) != 0) begin : g_bad_div
    $error("divide ratio must be even and at least two");
  end
  if (REF_CLK_KHZ < 4 * XTAL_MAX_KHZ) begin : g_bad_ref
    $error("ref_clk too slow to sample the fastest crystal");
  end
  if (XTAL_NOM_KHZ * 1000 / CORE_DIV != CORE_NOM_HZ) begin : g_bad_nom
    $error("nominal crystal and core clock disagree");
  end

  // ---------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------
  logic xtalLevel, xtalRise;
  logic pinLevel;

  // crystal output crosses into ref_clk domain
  pin_sampler u_xtal (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(xtalClk),
    .level(xtalLevel),
    .rise(xtalRise),
    .fall()
  );

  // shared clock pin input buffer
  pin_sampler u_pin (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(clkPinIn),
    .level(pinLevel),
    .rise(),
    .fall()
  );

  // ---------------------------------------------------------------
  // oscillator enable and divider
  // ---------------------------------------------------------------
  logic oscEn_reg, oscEn_next;
  logic [CW-1:0] divCnt_reg, divCnt_next;
  logic intClk_reg, intClk_next;

  // half-period counter on crystal rising edges gives 50 percent duty
  always_comb begin
    oscEn_next = ~ctrl.oscPowerDown;
    divCnt_next = divCnt_reg;
    intClk_next = intClk_reg;
    if (!oscEn_reg) begin
      divCnt_next = '0;
      intClk_next = RST_LEVEL;
    end else if (xtalRise) begin
      if (divCnt_reg == HALF_LAST) begin
        divCnt_next = '0;
        intClk_next = ~intClk_reg;
      end else begin
        divCnt_next = divCnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      oscEn_reg <= RST_OSC_EN;
      divCnt_reg <= '0;
      intClk_reg <= RST_LEVEL;
    end else begin
      oscEn_reg <= oscEn_next;
      divCnt_reg <= divCnt_next;
      intClk_reg <= intClk_next;
    end
  end

  // ---------------------------------------------------------------
  // glitch-free source select and gate
  // ---------------------------------------------------------------
  clock_source_t src_reg, src_next;
  logic gateOn_reg, gateOn_next;
  logic outEn_reg, outEn_next;
  logic curLevel, newLevel;
  clock_source_t reqSrc;

  // settings only change while both old and new source sit low
  always_comb begin
    reqSrc = ctrl.oscPowerDown ? SRC_EXTERNAL : SRC_INTERNAL;
    curLevel = (src_reg == SRC_EXTERNAL) ? pinLevel : intClk_reg;
    newLevel = (reqSrc == SRC_EXTERNAL) ? pinLevel : intClk_reg;
    src_next = src_reg;
    gateOn_next = gateOn_reg;
    outEn_next = outEn_reg;
    if (!curLevel && !newLevel) begin
      src_next = reqSrc;
      gateOn_next = ctrl.clockRunGate;
      outEn_next = ctrl.clockPinOutputEnable;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      src_reg <= SRC_INTERNAL;
      gateOn_reg <= RST_GATE;
      outEn_reg <= 1'h0;
    end else begin
      src_reg <= src_next;
      gateOn_reg <= gateOn_next;
      outEn_reg <= outEn_next;
    end
  end

  // ---------------------------------------------------------------
  // core clock and pin drive
  // ---------------------------------------------------------------
  logic coreClk_reg, coreClk_next;
  logic coreEn_reg, coreEn_next;
  logic pinOut_reg, pinOut_next;
  logic pinOeN_reg, pinOeN_next;
  logic drivePin;

  // core sees the gated source; pin driven only for internal source
  always_comb begin
    coreClk_next = gateOn_reg & curLevel;
    coreEn_next = coreClk_next & ~coreClk_reg;
    drivePin = gateOn_reg & outEn_reg
               & (src_reg == SRC_INTERNAL);
    pinOeN_next = ~drivePin;
    pinOut_next = drivePin & intClk_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      coreClk_reg <= RST_LEVEL;
      coreEn_reg <= 1'h0;
      pinOut_reg <= RST_LEVEL;
      pinOeN_reg <= RST_OE_N;
    end else begin
      coreClk_reg <= coreClk_next;
      coreEn_reg <= coreEn_next;
      pinOut_reg <= pinOut_next;
      pinOeN_reg <= pinOeN_next;
    end
  end

  assign oscEnable = oscEn_reg;
  assign coreClk = coreClk_reg;
  assign coreClkEn = coreEn_reg;
  assign clkPinOut = pinOut_reg;
  assign clkPinOe_n = pinOeN_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence coreRise;
    !coreClk_reg ##1 coreClk_reg;
  endsequence

  sequence gateHeldOff;
    !gateOn_reg [*2];
  endsequence

  AST_GATE_OFF_NO_CLOCK: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    gateHeldOff |-> !coreClk_reg && clkPinOe_n)
    else $error("clock seen while gate is off");

  AST_INT_FOLLOWS: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    gateOn_reg && src_reg == SRC_INTERNAL
    |=> coreClk_reg == $past(intClk_reg))
    else $error("core clock does not follow internal clock");

  AST_PIN_NEEDS_ENABLE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !clkPinOe_n |-> $past(outEn_reg) && $past(gateOn_reg))
    else $error("pin driven without output enable and gate");

  AST_EXT_RELEASES_PIN: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    src_reg == SRC_EXTERNAL |=> clkPinOe_n)
    else $error("pin driven while external source selected");

  AST_OSC_STOPS: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ctrl.oscPowerDown [*2] |-> !oscEnable ##1 !intClk_reg)
    else $error("oscillator not stopped by power-down");

  AST_EXT_FOLLOWS: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    gateOn_reg && src_reg == SRC_EXTERNAL
    |=> coreClk_reg == $past(pinLevel))
    else $error("core clock does not follow pin clock");

  AST_DIV_TOGGLE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $changed(intClk_reg) && $past(oscEn_reg)
    |-> $past(divCnt_reg) == HALF_LAST && $past(xtalRise))
    else $error("divided clock toggled off its count");

  AST_GATE_AT_LOW: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $changed(gateOn_reg) || $changed(src_reg)
    |-> $past(curLevel) == 1'h0)
    else $error("gate or source changed while clock high");

  AST_RISE_PULSE: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    coreRise |-> coreClkEn ##1 !coreClkEn)
    else $error("core rise not marked by one-cycle enable");

endmodule // clock_source_control

/* rtl/clock_source_pkg.sv */
// shared constants and types for the clock source control block
package clock_source_pkg;

  // ---------------------------------------------------------------
  // clock rates
  // ---------------------------------------------------------------
  localparam int REF_CLK_KHZ = 25000;    // ref_clk, 40 ns period
  localparam int XTAL_NOM_KHZ = 4096;    // nominal crystal
  localparam int XTAL_MIN_KHZ = 3700;    // lowest crystal accepted
  localparam int XTAL_MAX_KHZ = 4500;    // highest crystal accepted
  localparam int CORE_NOM_HZ = 409600;   // nominal core clock
  localparam int CORE_DIV = 10;          // crystal to core divide ratio

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic RST_GATE = 1'h0;
  localparam logic RST_OSC_EN = 1'h0;
  localparam logic RST_LEVEL = 1'h0;
  localparam logic RST_OE_N = 1'h1;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic clockRunGate;            // pass clock to the core
    logic oscPowerDown;            // stop crystal, take clock from pin
    logic clockPinOutputEnable;    // drive internal clock onto pin
  } oscillator_control_t;

  typedef enum logic [0:0] {
    SRC_INTERNAL = 1'b0,
    SRC_EXTERNAL = 1'b1
  } clock_source_t;

endpackage

/* rtl/pin_sampler.sv */
// two-flop synchroniser with edge detection for one pin
`timescale 1ns/100ps
module pin_sampler (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);

  logic meta_reg, meta_next;
  logic sync_reg, sync_next;
  logic prev_reg, prev_next;

  // ---------------------------------------------------------------
  // synchroniser and edge history
  // ---------------------------------------------------------------
  // next values; first stage feeds only the second stage
  always_comb begin
    meta_next = pinIn;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  // register stage, synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_reg <= 1'h0;
      sync_reg <= 1'h0;
      prev_reg <= 1'h0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  // edges seen on the settled stage only
  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;

endmodule // pin_sampler

/* testbench/clock_partner.sv */
// crystal and external clock chip on the shared clock pin
`timescale 1ns/100ps
module clock_partner (
  input wire logic oscEnable,
  input wire logic clkPinOut,
  input wire logic clkPinOe_n,
  input wire logic extOn,
  input var real xtalHalf,
  output logic xtalClk,
  output logic clkPinIn
);
  logic extClk = 1'h0;
  logic floatLvl = 1'h0;
  // crystal runs only while enabled, rests low when stopped
  initial begin
    xtalClk = 1'h0;
    #1;
    forever begin
      #(xtalHalf);
      xtalClk = (oscEnable === 1'h1) ? ~xtalClk : 1'h0;
    end
  end
  // other chip: free-running clock at half duty
  always #1220.7 extClk = ~extClk;
  // released pin keeps changing level
  always #40 floatLvl = ~clkPinIn;
  // pin level: device driver, else other chip, else floating
  assign clkPinIn = !clkPinOe_n ? clkPinOut :
    extOn ? extClk : floatLvl;
endmodule // clock_partner

/* testbench/test_clock_source_control.sv */
// self-checking bench for clock source selection and gating
`timescale 1ns/100ps
module test_clock_source_control;
  import clock_source_pkg::*;
  logic refClk, rstN, extOn, xtalClk, clkPinIn;
  logic oscEnable, clkPinOut, clkPinOe_n, coreClk, coreClkEn;
  oscillator_control_t ctrl;
  real xtalHalf;
  int n_mismatch, checked, minHigh, highRun;

  clock_source_control clock_source_control_i (.ref_clk(refClk),
    .rst_n(rstN), .ctrl(ctrl), .xtalClk(xtalClk), .clkPinIn(clkPinIn),
    .oscEnable(oscEnable), .clkPinOut(clkPinOut),
    .clkPinOe_n(clkPinOe_n), .coreClk(coreClk), .coreClkEn(coreClkEn));
  clock_partner clock_partner_i (.oscEnable(oscEnable),
    .clkPinOut(clkPinOut), .clkPinOe_n(clkPinOe_n), .extOn(extOn),
    .xtalHalf(xtalHalf), .xtalClk(xtalClk), .clkPinIn(clkPinIn));

  // 25 MHz reference
  initial begin
    refClk = 1'h0;
    forever #20 refClk = ~refClk;
  end

  // shortest high run of the core clock
  always @(negedge refClk) begin
    if (coreClk === 1'h1) begin
      highRun++;
    end else if (highRun > 0) begin
      if (highRun < minHigh) minHigh = highRun;
      highRun = 0;
    end
  end

  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check_eq(input logic [7:0] exp, input logic [7:0] act);
    checked++;
    if (act !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t exp=%0h got=%0h", $time, exp, act);
    end
  endtask

  task automatic check_near(input int exp, input int act, input int tol);
    checked++;
    if (act > exp + tol || act < exp - tol) begin
      n_mismatch++;
      $display("ERROR t=%0t exp=%0h got=%0h", $time, exp, act);
    end
  endtask

  task automatic set_ctrl(input logic [2:0] v);
    @(posedge refClk);
    #1 ctrl = v;
  endtask

  // count core rises, enable pulses, cycles driving pin = core clock
  task automatic watch(input int w, output int nRise, output int nEn,
    output int nOe);
    logic last;
    nRise = 0;
    nEn = 0;
    nOe = 0;
    last = coreClk;
    repeat (w) begin
      @(negedge refClk);
      if (coreClk === 1'h1 && last === 1'h0) nRise++;
      if (coreClkEn === 1'h1) nEn++;
      if (clkPinOe_n === 1'h0 && clkPinIn === coreClk) nOe++;
      last = coreClk;
    end
  endtask

  // bounded wait for the pin driver to switch on
  task automatic wait_oe;
    int i;
    for (i = 0; i < 100 && clkPinOe_n !== 1'h0; i++) @(negedge refClk);
    if (clkPinOe_n !== 1'h0) begin
      n_mismatch++;
      complete_run();
    end
  endtask

  task automatic t_reset;
    @(negedge refClk);
    check_eq(8'h04, {oscEnable, clkPinOut, clkPinOe_n, coreClk,
      coreClkEn});
  endtask

  task automatic t_gate_off;
    int r, e, o;
    set_ctrl(3'h1);
    watch(300, r, e, o);
    check_near(0, r + e, 0);
    check_eq(8'h03, {clkPinOe_n, oscEnable});
  endtask

  task automatic t_internal(input real half, input logic oe);
    int r, e, o, x;
    x = $rtoi(3050 * 40.0 / (2.0 * half * CORE_DIV) + 0.5);
    xtalHalf = half;
    set_ctrl({2'h0, oe});
    repeat (100) @(posedge refClk);
    set_ctrl({2'h2, oe});
    if (oe) wait_oe();
    watch(3050, r, e, o);
    check_near(x, r, 1);
    check_near(r, e, 1);
    check_near(oe ? 3050 : 0, o, 0);
    set_ctrl(3'h0);
    repeat (100) @(posedge refClk);
  endtask

  task automatic t_external;
    int r, e, o;
    extOn = 1'h1;
    set_ctrl(3'h3);
    repeat (100) @(posedge refClk);
    @(negedge refClk);
    check_eq(8'h01, {oscEnable, clkPinOe_n});
    set_ctrl(3'h7);
    watch(3050, r, e, o);
    check_near(50, r, 1);
    check_near(0, o, 0);
    set_ctrl(3'h2);
    repeat (100) @(posedge refClk);
    watch(300, r, e, o);
    check_near(0, r, 0);
    set_ctrl(3'h0);
    extOn = 1'h0;
    repeat (100) @(posedge refClk);
  endtask

  task automatic t_glitch;
    int i;
    xtalHalf = 122.07;
    minHigh = 1000;
    for (i = 0; i < 12; i++) begin
      set_ctrl(3'h4);
      repeat (37 + i * 13) @(posedge refClk);
      set_ctrl(3'h0);
      repeat (23 + i * 7) @(posedge refClk);
    end
    check_near($rtoi(CORE_DIV * 122.07 / 40.0), minHigh, 2);
  endtask

  initial begin
    ctrl = 3'h0;
    extOn = 1'h0;
    xtalHalf = 122.07;
    rstN = 1'h0;
    n_mismatch = 0;
    checked = 0;
    minHigh = 1000;
    highRun = 0;
    repeat (4) @(posedge refClk);
    t_reset();
    @(posedge refClk);
    #1 rstN = 1'h1;
    t_gate_off();
    t_internal(122.07, 1'h0);
    t_internal(122.07, 1'h1);
    t_internal(135.14, 1'h1);
    t_internal(111.11, 1'h0);
    t_external();
    t_glitch();
    complete_run();
  end
endmodule // test_clock_source_control
